// [logic/pums_params.svh]
`ifndef PUMS_PARAMS_SVH
`define PUMS_PARAMS_SVH
// Behaviour
// [RULE1] Board holds chip enable low, reconfig request and state pin high.
// [RULE2] Power-on reset clears every internal register.
// [RULE3] After reset, setup-complete output floats if the straps are right.
// [RULE4] Immediate mode: core runs straight after power-on reset.
// [RULE5] Delayed mode: core held in reset 50 ms more, then runs.
// [RULE6] Delayed mode drives setup-complete low during hold-off, then floats.
// [RULE7] No bitstream, emulation, remote upgrade or encrypted setup exists.
// [RULE8] Power-up mode is a fixed build option, constant in operation.
`define PUMS_CLK_HZ 40000000
`define PUMS_HOLD_MS 50
`define PUMS_HOLD_CYC ((`PUMS_CLK_HZ / 1000) * `PUMS_HOLD_MS)
`define PUMS_CNT_W 22
`define PUMS_TICK_DIV 40
`define PUMS_TICK_W 6
`define PUMS_SYNC_DEPTH 2
`endif

// [logic/pums_pkg.sv]
package pums_pkg;
    typedef enum logic [1:0] {
        PUMS_RESET = 2'b00,
        PUMS_HOLD  = 2'b01,
        PUMS_RUN   = 2'b11,
        PUMS_FAULT = 2'b10
    } pums_state_t;

    typedef struct packed {
        logic chip_enable_low;
        logic reconfig_request_low;
        logic config_state_pin_low;
    } pums_strap_t;

    typedef struct packed {
        pums_strap_t sync1;
        pums_strap_t sync2;
    } pums_sync_t;
endpackage

// [logic/pums_strap_sync.sv]
`timescale 1ns/1ps
`include "pums_params.svh"
module pums_strap_sync
    import pums_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire pums_strap_t strap_in,
    output pums_strap_t strap_sync
);
    pums_sync_t r;
    pums_sync_t next_r;

    // Two stages, only the second is read outside
    always_comb begin
        next_r = r;
        next_r.sync1 = strap_in;
        next_r.sync2 = r.sync1;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign strap_sync = r.sync2;
endmodule

// [logic/pums_sequencer.sv]
`timescale 1ns/1ps
`include "pums_params.svh"
module pums_sequencer
    import pums_pkg::*;
#(
    parameter bit DELAYED_MODE = 1'b0,
    parameter int HOLD_TICKS = `PUMS_HOLD_CYC / `PUMS_TICK_DIV
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic chip_enable_low,
    input wire logic reconfig_request_low,
    input wire logic config_state_pin_low,
    output logic core_reset_n,
    output logic setup_complete_out,
    output logic setup_complete_oe_n,
    output logic straps_ok
);
    typedef struct packed {
        pums_state_t state;
        logic [`PUMS_TICK_W-1:0] div;
        logic [`PUMS_CNT_W-1:0] ticks;
        logic core_on;
        logic drive_low;
        logic [1:0] settle;
    } pums_core_t;

    // Edges after reset before the strap synchroniser output is valid
    localparam logic [1:0] SETTLE_DONE = 2'(`PUMS_SYNC_DEPTH);

    localparam logic [`PUMS_TICK_W-1:0] TICK_LAST =
        `PUMS_TICK_W'(`PUMS_TICK_DIV - 1);
    localparam logic [`PUMS_CNT_W-1:0] TICKS_LAST =
        `PUMS_CNT_W'(HOLD_TICKS - 1);

    pums_core_t r;
    pums_core_t next_r;
    pums_strap_t straps;
    logic tick;
    logic sync_valid;

    ////////////////////////////////////////////////////////////////////////
    // Straps come from board pins, so they are synchronised first
    pums_strap_sync u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .strap_in({chip_enable_low, reconfig_request_low,
                   config_state_pin_low}),
        .strap_sync(straps)
    );

    // Straps must read low, high, high; the board keeps them so [RULE1]
    assign straps_ok = !straps.chip_enable_low &&
                       straps.reconfig_request_low &&
                       straps.config_state_pin_low;

    // Timebase enable, one pulse per microsecond
    assign tick = (r.div == TICK_LAST);

    // Synchroniser flops are cleared by reset and read as bad straps,
    // so a strap fault is only believed once they have refilled
    assign sync_valid = (r.settle == SETTLE_DONE); // [RULE3]

    ////////////////////////////////////////////////////////////////////////
    // Mode is a parameter, so no pin or bus can change it live [RULE8]
    // No configuration port exists at all; function is fixed [RULE7]
    always_comb begin
        next_r = r;
        next_r.div = tick ? '0 : r.div + 1'b1;
        // Count the synchroniser fill; saturates so it never wraps
        if (r.settle != SETTLE_DONE) begin
            next_r.settle = r.settle + 1'b1;
        end
        case (r.state)
            PUMS_RESET: begin
                if (DELAYED_MODE) begin
                    next_r.state = PUMS_HOLD; // [RULE5]
                    next_r.drive_low = 1'b1; // [RULE6]
                    next_r.ticks = '0;
                    next_r.div = '0;
                end else begin
                    next_r.state = PUMS_RUN; // [RULE4]
                    next_r.core_on = 1'b1;
                end
            end
            PUMS_HOLD: begin
                if (tick) begin
                    next_r.ticks = r.ticks + 1'b1;
                    if (r.ticks == TICKS_LAST) begin
                        next_r.state = PUMS_RUN; // [RULE5]
                        next_r.core_on = 1'b1;
                        next_r.drive_low = 1'b0; // [RULE6]
                    end
                end
            end
            PUMS_RUN: begin
                next_r.core_on = 1'b1;
            end
            default: begin
                next_r.state = PUMS_RESET;
                next_r.core_on = 1'b0;
                next_r.drive_low = 1'b0;
            end
        endcase
    end

    // Power-on reset clears everything; no strap is latched here [RULE2]
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin floats unless holding off; once the core runs on settled straps, floating also needs good straps
    assign core_reset_n = r.core_on;
    assign setup_complete_out = 1'b0; // Only ever driven low
    assign setup_complete_oe_n = !(r.drive_low ||
                                   (!straps_ok && r.core_on &&
                                    sync_valid)); // [RULE3]

    ////////////////////////////////////////////////////////////////////////
    sequence hold_run_s;
        r.state == PUMS_HOLD ##1 r.state == PUMS_RUN;
    endsequence

    // Delayed build leaves reset state straight into hold-off
    sequence enter_hold_s;
        DELAYED_MODE && r.state == PUMS_RESET ##1 r.state == PUMS_HOLD;
    endsequence

    por_clear_a: assert property (@(posedge clock) // [RULE2]
        $rose(rst_n) |-> !core_reset_n)
        else $error("core left reset at power-on");

    float_after_a: assert property (@(posedge clock) disable iff (!rst_n)
        (core_reset_n && straps_ok) |-> setup_complete_oe_n) // [RULE3]
        else $error("setup complete not floating");

    instant_on_a: assert property (@(posedge clock) disable iff (!rst_n)
        !DELAYED_MODE && r.state == PUMS_RESET |=> core_reset_n) // [RULE4]
        else $error("immediate mode did not start");

    hold_reset_a: assert property (@(posedge clock) disable iff (!rst_n)
        r.state == PUMS_HOLD |-> !core_reset_n) // [RULE5]
        else $error("core ran during hold-off");

    hold_end_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE5]
        hold_run_s |-> core_reset_n && $past(r.ticks) == TICKS_LAST)
        else $error("hold-off ended at wrong count");

    drive_low_a: assert property (@(posedge clock) disable iff (!rst_n)
        r.state == PUMS_HOLD |-> !setup_complete_oe_n) // [RULE6]
        else $error("setup complete not driven in hold-off");

    release_a: assert property (@(posedge clock) disable iff (!rst_n)
        hold_run_s |-> (straps_ok -> setup_complete_oe_n)) // [RULE6]
        else $error("setup complete not released");

    mode_fixed_a: assert property (@(posedge clock) disable iff (!rst_n)
        r.state == PUMS_RUN |=> r.state == PUMS_RUN) // [RULE8]
        else $error("sequencer left run state");

    ////////////////////////////////////////////////////////////////////////
    // Reset values seen on the first edge after release
    reset_clear_a: assert property (@(posedge clock) // [RULE2]
        $rose(rst_n) |-> r.state == PUMS_RESET && !r.drive_low)
        else $error("state not cleared by reset");

    // Pin data is a constant low; only the enable moves
    out_low_a: assert property (@(posedge clock) // [RULE6]
        !setup_complete_out)
        else $error("setup complete data not low");

    // Straps read as faulty after settling must pull the pin low
    fault_drive_a: assert property (@(posedge clock) // [RULE3]
        disable iff (!rst_n)
        (sync_valid && core_reset_n && !straps_ok) |-> !setup_complete_oe_n)
        else $error("bad straps did not drive pin");

    // Before the synchroniser fills, only hold-off may drive the pin
    settle_gate_a: assert property (@(posedge clock) // [RULE3]
        disable iff (!rst_n)
        !sync_valid |-> (setup_complete_oe_n == !r.drive_low))
        else $error("pin driven on unsettled straps");

    // First hold-off cycle already drives the pin low
    hold_entry_a: assert property (@(posedge clock) // [RULE6]
        disable iff (!rst_n)
        enter_hold_s |-> !setup_complete_oe_n && !core_reset_n)
        else $error("hold-off entry wrong");

    // Timebase pulses are single cycles, never back to back
    tick_gap_a: assert property (@(posedge clock) // [RULE5]
        disable iff (!rst_n)
        tick |=> !tick)
        else $error("timebase pulse too long");

    // Hold-off count only moves on a timebase pulse
    hold_count_a: assert property (@(posedge clock) // [RULE5]
        disable iff (!rst_n)
        (r.state == PUMS_HOLD && !tick) |=> r.ticks == $past(r.ticks))
        else $error("hold-off count moved without tick");

    // Run state always has the core out of reset
    run_core_a: assert property (@(posedge clock) // [RULE4]
        disable iff (!rst_n)
        r.state == PUMS_RUN |-> core_reset_n)
        else $error("core held in run state");

    // Spare encoding is never reached from a clean reset
    no_fault_a: assert property (@(posedge clock) // [RULE8]
        disable iff (!rst_n)
        r.state != PUMS_FAULT)
        else $error("sequencer in spare state");
endmodule

// [sim/pums_board_model.sv]
`timescale 1ns/1ps
module pums_board_model
    import pums_pkg::*;
(
    input wire logic strap_fault,
    input wire logic done_data,
    input wire logic done_oe_n,
    output pums_strap_t straps,
    output wire logic done_wire
);
    // Straps sit at their required levels unless a fault is commanded
    assign straps = '{strap_fault, 1'h1, 1'h1};
    // Open-drain pin with a board pull-up, so a float reads high
    assign done_wire = done_oe_n ? 1'h1 : done_data;
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench import pums_pkg::*;;
    localparam int HT = 3;
    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic fault = 1'h0;
    int error_cnt = 0;
    int total_checks = 0;
    int n;
    pums_strap_t st_i, st_d;
    logic cr_i, cr_d, sc_i, sc_d, oe_i, oe_d, ok_i, ok_d, pin_i, pin_d;
    always #12.5 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    // Immediate and delayed builds side by side, one board each
    pums_board_model brd_i (.strap_fault(fault), .done_data(sc_i),
        .done_oe_n(oe_i), .straps(st_i), .done_wire(pin_i));
    pums_board_model brd_d (.strap_fault(1'h0), .done_data(sc_d),
        .done_oe_n(oe_d), .straps(st_d), .done_wire(pin_d));
    pums_sequencer #(.DELAYED_MODE(1'h0), .HOLD_TICKS(HT)) dut (
        .clock(clock), .rst_n(rst_n), .chip_enable_low(st_i[2]),
        .reconfig_request_low(st_i[1]), .config_state_pin_low(st_i[0]),
        .core_reset_n(cr_i), .setup_complete_out(sc_i),
        .setup_complete_oe_n(oe_i), .straps_ok(ok_i));
    pums_sequencer #(.DELAYED_MODE(1'h1), .HOLD_TICKS(HT)) dut_dly (
        .clock(clock), .rst_n(rst_n), .chip_enable_low(st_d[2]),
        .reconfig_request_low(st_d[1]), .config_state_pin_low(st_d[0]),
        .core_reset_n(cr_d), .setup_complete_out(sc_d),
        .setup_complete_oe_n(oe_d), .straps_ok(ok_d));
    ////////////////////////////////////////////////////////////////////////
    task automatic check_bit(string name, logic exp, logic got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Inputs move 1 ns after the edge so no race with the sampling
    task automatic step(int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    // Delayed build: pin pulled low all through hold-off, bounded wait
    task automatic hold_off();
        n = 1;
        while (cr_d !== 1'h1 && n < 400) begin
            check_bit("pin_d hold", 1'h0, pin_d);
            step(1);
            n++;
        end
        if (n >= 400) begin
            error_cnt++;
            tally_and_finish();
        end
        check_bit("hold len", 1'h1, n == HT * 40 + 1);
        check_bit("pin_d end", 1'h1, pin_d);
        check_bit("ok_d end", 1'h1, ok_d);
        check_bit("sc_d end", 1'h0, sc_d);
    endtask
    // Bad strap while running drives the pin low until it is put right
    task automatic strap_fault();
        fault = 1'h1;
        step(3);
        check_bit("ok_i bad", 1'h0, ok_i);
        check_bit("pin_i bad", 1'h0, pin_i);
        fault = 1'h0;
        step(3);
        check_bit("pin_i good", 1'h1, pin_i);
    endtask
    // Second reset in mid-run: both clear, modes come back unchanged
    task automatic rerun();
        rst_n = 1'h0;
        step(1);
        check_bit("cr_i rst", 1'h0, cr_i);
        check_bit("cr_d rst", 1'h0, cr_d);
        rst_n = 1'h1;
        step(1);
        check_bit("cr_i again", 1'h1, cr_i);
        check_bit("pin_d again", 1'h0, pin_d);
        hold_off();
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        step(20);
        check_bit("cr_i por", 1'h0, cr_i);
        check_bit("cr_d por", 1'h0, cr_d);
        check_bit("pin_i por", 1'h1, pin_i);
        rst_n = 1'h1;
        step(1);
        check_bit("cr_i run", 1'h1, cr_i);
        check_bit("pin_i run", 1'h1, pin_i);
        check_bit("sc_i zero", 1'h0, sc_i);
        check_bit("cr_d held", 1'h0, cr_d);
        hold_off();
        strap_fault();
        rerun();
        tally_and_finish();
    end
endmodule
